// >>> hw/ptr_pkg.sv
// Constants and carriers shared by the telemetry readback bank
`default_nettype none
package ptr_pkg;
  // Command codes
  localparam logic [7:0] CMD_VIN = 8'h88;
  localparam logic [7:0] CMD_IIN_TOTAL = 8'h89;
  localparam logic [7:0] CMD_VOUT = 8'h8b;
  localparam logic [7:0] CMD_IOUT = 8'h8c;
  localparam logic [7:0] CMD_TEMP_EXT = 8'h8d;
  localparam logic [7:0] CMD_TEMP_INT = 8'h8e;
  localparam logic [7:0] CMD_DUTY = 8'h94;
  localparam logic [7:0] CMD_POUT = 8'h96;
  localparam logic [7:0] CMD_IOUT_PEAK = 8'hd7;
  localparam logic [7:0] CMD_VOUT_PEAK = 8'hdd;
  localparam logic [7:0] CMD_VIN_PEAK = 8'hde;
  localparam logic [7:0] CMD_TEMP_EXT_PEAK = 8'hdf;
  localparam logic [7:0] CMD_IIN_CHAN = 8'hed;
  localparam logic [7:0] CMD_TEMP_INT_PEAK = 8'hf4;
  localparam logic [7:0] CMD_ECC_INFO = 8'hb6;
  // ECC info word layout
  localparam int ECC_BIT_POS = 5;
  localparam int ECC_RSVD_HI_W = 10;
  localparam int ECC_RSVD_LO_W = 5;
  // Widths
  localparam int SENSE_W = 16;
  localparam int DUTY_W = 10;
  localparam int VOUT_W = 16;
  localparam int VIN_W = 16;
  localparam int TEMP_W = 16;
  localparam int IOUT_W = 24;
  localparam int IIN_W = 36;
  localparam int PARAM_W = 16;
  localparam int EXP_W = 5;
  localparam int LIN_W = 16;
  localparam int MANT_W = 11;
  localparam int ENC_W = 64;
  // Fixed-point exponents of raw quantities
  localparam int IOUT_EXP = -4;
  localparam int TEMP_EXP = -2;
  localparam int VIN_EXP = -8;
  localparam int DUTY_EXP = -10;
  localparam int IIN_EXP = IOUT_EXP - DUTY_W;
  localparam int DUTY_PCT_SCALE = 100;
  // Calibration arithmetic
  localparam int TEMP_GAIN_SHIFT = 14;
  localparam int TC_SHIFT = 20;
  localparam int GAIN_SHIFT = 10;
  localparam int TEMP_REF_RAW = 100;
  // Linear 5s/11s limits
  localparam int EXP_MAX = 15;
  localparam int EXP_MIN = -16;
  localparam int MANT_MAX = 1023;
  localparam int MANT_MIN = -1024;
  localparam int ENC_STEPS = 56;
  // Reset values
  localparam logic ECC_NOCORR_RST = 1'b0;
  localparam logic ECC_PEND_RST = 1'b1;
  localparam logic [LIN_W-1:0] RD_DATA_RST = 16'h0000;

  typedef struct packed {
    logic [SENSE_W-1:0] senseRaw;
    logic [DUTY_W-1:0] duty;
    logic [VOUT_W-1:0] voutRaw;
    logic [TEMP_W-1:0] extTempRaw;
  } ptr_sample_type;

  typedef struct packed {
    logic [VIN_W-1:0] vinRaw;
    logic [TEMP_W-1:0] intTempRaw;
  } ptr_common_type;

  typedef struct packed {
    logic [PARAM_W-1:0] calGain;
    logic [PARAM_W-1:0] gainTc;
    logic [PARAM_W-1:0] tempGain;
    logic [PARAM_W-1:0] tempOffset;
    logic [PARAM_W-1:0] iinOffset;
    logic [EXP_W-1:0] voutExp;
  } ptr_cfg_type;

  typedef struct packed {
    logic [1:0][VOUT_W-1:0] vout;
    logic [1:0][IOUT_W-1:0] iout;
    logic [1:0][TEMP_W-1:0] extTemp;
    logic [1:0][DUTY_W-1:0] duty;
    logic [1:0][IIN_W-1:0] iinCh;
    logic [1:0][LIN_W-1:0] pout;
    logic [VIN_W-1:0] vin;
    logic [TEMP_W-1:0] intTemp;
    logic eccNoCorr;
    logic eccPending;
    logic ack;
    logic unsup;
    logic [LIN_W-1:0] data;
    logic [7:0] code;
    logic page;
  } ptr_state_type;
endpackage
`default_nettype wire

// >>> hw/ptr_peak_hold.sv
// Running maximum of one measurement with clear
`default_nettype none
module ptr_peak_hold #(
  parameter int WIDTH = 16,
  parameter bit IS_SIGNED = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Measurement and clear
  input wire logic clear,
  input wire logic sampleValid,
  input wire logic [WIDTH-1:0] sample,
  // Held maximum
  output logic [WIDTH-1:0] peak,
  output logic held
);
  typedef struct packed {
    logic [WIDTH-1:0] peak;
    logic held;
  } ptr_peak_state_type;

  ptr_peak_state_type q, d;
  logic bigger;

  if (WIDTH < 2) begin : gWidthCheck
    $error("ptr_peak_hold: WIDTH too small");
  end

  always_comb begin
    d = q;
    bigger = IS_SIGNED ? ($signed(sample) > $signed(q.peak)) : (sample > q.peak);
    // New sample beats a pending clear
    if (sampleValid && (clear || !q.held || bigger)) begin
      d.peak = sample;
      d.held = 1'b1;
    end else if (clear) begin
      d.peak = '0;
      d.held = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign peak = q.peak;
  assign held = q.held;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  peakGrow_a: assert property (sampleValid && !clear && q.held && bigger |=> q.peak == $past(sample))
    else $error("peak did not take larger sample");
  clearDrop_a: assert property (clear && !sampleValid |=> !q.held ##1 (!q.held || q.peak == $past(sample)))
    else $error("peak not cleared or not resumed");
endmodule
`default_nettype wire

// >>> hw/ptr_readback_bank.sv
// Telemetry readback bank answering word reads by command code
`default_nettype none
module ptr_readback_bank
  import ptr_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Measurement posting
  input wire logic sampleValid,
  input wire logic sampleChan,
  input wire ptr_sample_type smp,
  input wire logic commonValid,
  input wire ptr_common_type common,
  // Calibration per channel
  input wire ptr_cfg_type [CHANNELS-1:0] chanCfg,
  // Peak clear request
  input wire logic clearPeaks,
  // Nonvolatile memory ECC events
  input wire logic eccNoCorrect,
  input wire logic eccRestoreDone,
  input wire logic eccResetCmd,
  input wire logic eccBulkRead,
  // Word read port
  input wire logic page,
  input wire logic rdReq,
  input wire logic [7:0] rdCode,
  output logic rdAck,
  output logic [LIN_W-1:0] rdData,
  output logic rdUnsupported
);
  ptr_state_type q, d;
  ptr_cfg_type cfg;
  logic signed [ENC_W-1:0] tMul, dT, gMul, gComp, iMul, iinFix, pMul;
  logic signed [TEMP_W-1:0] tCorr;
  logic signed [IOUT_W-1:0] ioutNew;
  logic [1:0][VOUT_W-1:0] voutPk;
  logic [1:0][IOUT_W-1:0] ioutPk;
  logic [1:0][TEMP_W-1:0] extTempPk;
  logic [VIN_W-1:0] vinPk;
  logic [TEMP_W-1:0] intTempPk;

  if (CHANNELS != 2) begin : gChanCheck
    $error("ptr_readback_bank: one page bit serves two channels only");
  end

  // Pack a fixed-point value into exponent/mantissa form
  function automatic logic [LIN_W-1:0] lin11(input logic signed [ENC_W-1:0] v, input int baseExp);
    logic signed [ENC_W-1:0] m;
    int e;
    m = v;
    e = baseExp;
    for (int i = 0; i < ENC_STEPS; i++) begin
      if ((m > MANT_MAX || m < MANT_MIN || e < EXP_MIN) && e < EXP_MAX) begin
        m = m >>> 1;
        e = e + 1;
      end
    end
    if (m > MANT_MAX) begin
      m = MANT_MAX;
    end
    if (m < MANT_MIN) begin
      m = MANT_MIN;
    end
    return {e[EXP_W-1:0], m[MANT_W-1:0]};
  endfunction

  // Peak trackers for output voltage, output current, external temperature, input voltage and internal temperature
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : gPeak
    ptr_peak_hold #(.WIDTH(VOUT_W), .IS_SIGNED(1'b0)) uVoutPk (
      .mclk(mclk),
      .rst(rst),
      .clear(clearPeaks),
      .sampleValid(sampleValid && (sampleChan == 1'(ch))),
      .sample(smp.voutRaw),
      .peak(voutPk[ch]),
      .held()
    );
    ptr_peak_hold #(.WIDTH(IOUT_W), .IS_SIGNED(1'b1)) uIoutPk (
      .mclk(mclk),
      .rst(rst),
      .clear(clearPeaks),
      .sampleValid(sampleValid && (sampleChan == 1'(ch))),
      .sample(ioutNew),
      .peak(ioutPk[ch]),
      .held()
    );
    ptr_peak_hold #(.WIDTH(TEMP_W), .IS_SIGNED(1'b1)) uTempPk (
      .mclk(mclk),
      .rst(rst),
      .clear(clearPeaks),
      .sampleValid(sampleValid && (sampleChan == 1'(ch))),
      .sample(tCorr),
      .peak(extTempPk[ch]),
      .held()
    );
  end

  ptr_peak_hold #(.WIDTH(VIN_W), .IS_SIGNED(1'b0)) uVinPk (
    .mclk(mclk),
    .rst(rst),
    .clear(clearPeaks),
    .sampleValid(commonValid),
    .sample(common.vinRaw),
    .peak(vinPk),
    .held()
  );

  ptr_peak_hold #(.WIDTH(TEMP_W), .IS_SIGNED(1'b1)) uIntTempPk (
    .mclk(mclk),
    .rst(rst),
    .clear(clearPeaks),
    .sampleValid(commonValid),
    .sample(common.intTempRaw),
    .peak(intTempPk),
    .held()
  );

  always_comb begin
    d = q;
    cfg = chanCfg[sampleChan];
    // Corrected external temperature is the only one used downstream
    tMul = $signed(smp.extTempRaw) * $signed({1'b0, cfg.tempGain});
    tMul = (tMul >>> TEMP_GAIN_SHIFT) + $signed(cfg.tempOffset);
    tCorr = TEMP_W'(tMul);
    // Sense gain compensated against external temperature
    dT = $signed(tCorr) - ENC_W'(TEMP_REF_RAW);
    gMul = ($signed(cfg.gainTc) * dT * $signed({1'b0, cfg.calGain})) >>> TC_SHIFT;
    gComp = $signed({1'b0, cfg.calGain}) + gMul;
    iMul = ($signed(smp.senseRaw) * gComp) >>> GAIN_SHIFT;
    ioutNew = IOUT_W'(iMul);
    iinFix = ($signed(cfg.iinOffset) <<< DUTY_W) + ioutNew * $signed({1'b0, smp.duty});
    // Power from the same sample's voltage and current
    pMul = $signed({1'b0, smp.voutRaw}) * ioutNew;

    if (sampleValid) begin
      d.vout[sampleChan] = smp.voutRaw;
      d.iout[sampleChan] = ioutNew;
      d.extTemp[sampleChan] = tCorr;
      d.duty[sampleChan] = smp.duty;
      d.iinCh[sampleChan] = IIN_W'(iinFix);
      d.pout[sampleChan] = lin11(pMul, int'($signed(cfg.voutExp)) + IOUT_EXP);
    end

    // Internal temperature is stored and reported only
    if (commonValid) begin
      d.vin = common.vinRaw;
      d.intTemp = common.intTempRaw;
    end

    // ECC status sampled after reset release and on refresh events
    if (q.eccPending || eccRestoreDone || eccResetCmd || eccBulkRead) begin
      d.eccNoCorr = eccNoCorrect;
      d.eccPending = 1'b0;
    end

    d.ack = 1'b0;
    if (rdReq) begin
      d.ack = 1'b1;
      d.code = rdCode;
      d.page = page;
      d.unsup = 1'b0;
      case (rdCode)
        CMD_VIN: begin
          d.data = lin11(ENC_W'(q.vin), VIN_EXP);
        end
        CMD_IIN_TOTAL: begin
          d.data = lin11(ENC_W'($signed(q.iinCh[0])) + ENC_W'($signed(q.iinCh[1])), IIN_EXP);
        end
        CMD_IIN_CHAN: begin
          d.data = lin11(ENC_W'($signed(q.iinCh[page])), IIN_EXP);
        end
        CMD_VOUT: begin
          d.data = q.vout[page];
        end
        CMD_IOUT: begin
          d.data = lin11(ENC_W'($signed(q.iout[page])), IOUT_EXP);
        end
        CMD_TEMP_EXT: begin
          d.data = lin11(ENC_W'($signed(q.extTemp[page])), TEMP_EXP);
        end
        CMD_TEMP_INT: begin
          d.data = lin11(ENC_W'($signed(q.intTemp)), TEMP_EXP);
        end
        CMD_DUTY: begin
          d.data = lin11(ENC_W'(q.duty[page]) * ENC_W'(DUTY_PCT_SCALE), DUTY_EXP);
        end
        CMD_POUT: begin
          d.data = q.pout[page];
        end
        CMD_VOUT_PEAK: begin
          d.data = voutPk[page];
        end
        CMD_VIN_PEAK: begin
          d.data = lin11(ENC_W'(vinPk), VIN_EXP);
        end
        CMD_TEMP_EXT_PEAK: begin
          d.data = lin11(ENC_W'($signed(extTempPk[page])), TEMP_EXP);
        end
        CMD_TEMP_INT_PEAK: begin
          d.data = lin11(ENC_W'($signed(intTempPk)), TEMP_EXP);
        end
        CMD_IOUT_PEAK: begin
          d.data = lin11(ENC_W'($signed(ioutPk[page])), IOUT_EXP);
        end
        CMD_ECC_INFO: begin
          d.data = {{ECC_RSVD_HI_W{1'b0}}, q.eccNoCorr, {ECC_RSVD_LO_W{1'b0}}};
        end
        default: begin
          d.data = RD_DATA_RST;
          d.unsup = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.eccNoCorr <= ECC_NOCORR_RST;
      q.eccPending <= ECC_PEND_RST;
      q.data <= RD_DATA_RST;
    end else begin
      q <= d;
    end
  end

  assign rdAck = q.ack;
  assign rdData = q.data;
  assign rdUnsupported = q.unsup;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  readAnswer_a: assert property (rdReq |=> rdAck ##1 (!rdAck || $past(rdReq)))
    else $error("read not answered in one cycle");
  eccWord_a: assert property (rdReq && rdCode == CMD_ECC_INFO |=> rdData == {10'h000, $past(q.eccNoCorr), 5'h00})
    else $error("ECC info word wrong");
  eccHold_a: assert property (!eccRestoreDone && !eccResetCmd && !eccBulkRead && !q.eccPending |=> $stable(q.eccNoCorr))
    else $error("ECC status changed without event");
  eccRefresh_a: assert property (eccBulkRead || eccResetCmd || eccRestoreDone |=> q.eccNoCorr == $past(eccNoCorrect))
    else $error("ECC status not refreshed");
  vinUnpaged_a: assert property (rdReq && rdCode == CMD_VIN |=> rdData == lin11(ENC_W'($past(q.vin)), VIN_EXP))
    else $error("input voltage read wrong");
  voutPaged_a: assert property (rdReq && rdCode == CMD_VOUT |=> rdData == $past(q.vout[page]))
    else $error("output voltage not from selected page");
  iinSum_a: assert property (rdReq && rdCode == CMD_IIN_TOTAL |=>
    rdData == lin11(ENC_W'($signed($past(q.iinCh[0]))) + ENC_W'($signed($past(q.iinCh[1]))), IIN_EXP))
    else $error("total input current is not the channel sum");
  intTempSolo_a: assert property (commonValid && !sampleValid |=> q.intTemp == $past(common.intTempRaw) && $stable(q.extTemp))
    else $error("internal temperature handling wrong");
  voutPeakTrack_a: assert property (sampleValid |=> voutPk[$past(sampleChan)] >= $past(smp.voutRaw))
    else $error("output voltage peak below posted reading");

  eccRead_c: cover property (eccBulkRead ##1 rdReq && rdCode == CMD_ECC_INFO ##1 rdAck);
  peakClear_c: cover property (sampleValid ##1 clearPeaks ##1 sampleValid);
  page1Power_c: cover property (rdReq && page && rdCode == CMD_POUT);
  unsupported_c: cover property (rdUnsupported);
endmodule
`default_nettype wire

// >>> bench/ptr_host_model.sv
// Host model issuing telemetry word reads
`default_nettype none
module ptr_host_model
  import ptr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Read request
  output logic rdReq,
  output logic [7:0] rdCode,
  output logic page,
  // Answer
  input wire logic rdAck,
  input wire logic [LIN_W-1:0] rdData,
  input wire logic rdUnsupported
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rdReq = 1'b0;
    rdCode = 8'h00;
    page = 1'b0;
  end

  // Gap of idle cycles lets the bench act as a slow host
  task automatic read(input logic [7:0] code, input logic pg, input int gap,
                      output logic [LIN_W-1:0] data, output logic unsup, output logic ok);
    int n;
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    rdReq <= 1'b1;
    rdCode <= code;
    page <= pg;
    @(posedge mclk);
    rdReq <= 1'b0;
    // Scrambled code once taken
    rdCode <= ~code;
    ok = 1'b0;
    data = 16'h0000;
    unsup = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge mclk);
      if (rdAck === 1'b1) begin
        data = rdData;
        unsup = rdUnsupported;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/ptr_readback_bank_test.sv
// Self-checking bench of the telemetry readback bank
`default_nettype none
module ptr_readback_bank_test
  import ptr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] code;
    logic pg;
    logic unsup;
    logic [15:0] exp;
  } ptr_row_type;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] ev = 6'h00;
  logic sampleChan = 1'b0;
  ptr_sample_type smp = '0;
  ptr_common_type common = '0;
  ptr_cfg_type [1:0] chanCfg;
  logic eccNoCorrect = 1'b1;
  logic rdReq;
  logic [7:0] rdCode;
  logic page;
  logic rdAck;
  logic [LIN_W-1:0] rdData;
  logic rdUnsupported;
  int nErrors = 0;
  int nCompared = 0;
  int hostGap = 0;
  logic [3:0] eccVal = 4'ha;
  logic [3:0][5:0] eccMask = {6'h08, 6'h04, 6'h02, 6'h08};
  ptr_row_type rows [24] = '{
    {CMD_VIN, 2'b00, 16'hc200}, {CMD_VIN, 2'b10, 16'hc200},
    {CMD_IIN_TOTAL, 2'b10, 16'hd2c0}, {CMD_IIN_CHAN, 2'b00, 16'hd240},
    {CMD_IIN_CHAN, 2'b10, 16'hc200}, {CMD_VOUT, 2'b00, 16'h1000},
    {CMD_VOUT, 2'b10, 16'h0800}, {CMD_IOUT, 2'b00, 16'he100},
    {CMD_IOUT, 2'b10, 16'he080}, {CMD_TEMP_EXT, 2'b00, 16'hf064},
    {CMD_TEMP_EXT, 2'b10, 16'hf0c8}, {CMD_TEMP_INT, 2'b10, 16'hf064},
    {CMD_DUTY, 2'b00, 16'he320}, {CMD_DUTY, 2'b10, 16'hdb20},
    {CMD_POUT, 2'b00, 16'hda00}, {CMD_POUT, 2'b10, 16'hca00},
    {CMD_VOUT_PEAK, 2'b00, 16'h1000}, {CMD_VOUT_PEAK, 2'b10, 16'h0800},
    {CMD_VIN_PEAK, 2'b10, 16'hc200}, {CMD_TEMP_EXT_PEAK, 2'b10, 16'hf0c8},
    {CMD_TEMP_INT_PEAK, 2'b00, 16'hf064}, {CMD_IOUT_PEAK, 2'b00, 16'he100},
    {8'h00, 2'b01, 16'h0000}, {CMD_ECC_INFO, 2'b10, 16'h0020}
  };

  always #12.5ns mclk = ~mclk;

  ptr_readback_bank u_dut (
    .mclk(mclk), .rst(rst), .sampleValid(ev[5]), .sampleChan(sampleChan), .smp(smp),
    .commonValid(ev[4]), .common(common), .chanCfg(chanCfg), .clearPeaks(ev[0]),
    .eccNoCorrect(eccNoCorrect), .eccRestoreDone(ev[1]), .eccResetCmd(ev[2]), .eccBulkRead(ev[3]),
    .page(page), .rdReq(rdReq), .rdCode(rdCode), .rdAck(rdAck), .rdData(rdData),
    .rdUnsupported(rdUnsupported)
  );

  ptr_host_model u_host (
    .mclk(mclk), .rdReq(rdReq), .rdCode(rdCode), .page(page), .rdAck(rdAck), .rdData(rdData),
    .rdUnsupported(rdUnsupported)
  );

  task automatic conclude();
    if (nErrors == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkFlag(input logic got, input logic exp);
    checkWord({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic readExpect(input logic [7:0] code, input logic pg, input logic [15:0] exp, input logic unsupExp);
    logic [15:0] d;
    logic u;
    logic ok;
    u_host.read(code, pg, hostGap, d, u, ok);
    checkFlag(ok, 1'b1);
    checkFlag(u, unsupExp);
    checkWord(d, exp);
  endtask

  // Posts events, a channel sample and a common sample together
  task automatic fire(input logic [5:0] mask, input logic ch, input ptr_sample_type s, input ptr_common_type c);
    @(posedge mclk);
    ev <= mask;
    sampleChan <= ch;
    smp <= s;
    common <= c;
    @(posedge mclk);
    ev <= 6'h00;
    smp <= ~smp;
    common <= ~common;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    nErrors++;
    conclude();
  end

  initial begin
    chanCfg[0] = '{16'h0400, 16'h0000, 16'h4000, 16'h0000, 16'h0010, 5'h14};
    chanCfg[1] = '{16'h0400, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 5'h14};
    repeat (3) @(posedge mclk);
    checkFlag(rdAck, 1'b0);
    checkFlag(rdUnsupported, 1'b0);
    checkWord(rdData, 16'h0000);
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    readExpect(CMD_ECC_INFO, 1'b0, 16'h0020, 1'b0);
    fire(6'h20, 1'b0, '{16'h0100, 10'h200, 16'h1000, 16'h0064}, '0);
    fire(6'h30, 1'b1, '{16'h0080, 10'h100, 16'h0800, 16'h00c8}, '{16'h0200, 16'h0064});
    // Prompt host, then slow host
    for (int g = 0; g < 2; g++) begin
      hostGap = g * 3;
      foreach (rows[i]) readExpect(rows[i].code, rows[i].pg, rows[i].exp, rows[i].unsup);
    end
    hostGap = 0;
    // Smaller sample leaves peaks, larger input voltage raises its peak
    fire(6'h30, 1'b0, '{16'h0040, 10'h200, 16'h0800, 16'h0032}, '{16'h0300, 16'h0064});
    fire(6'h10, 1'b0, '0, '{16'h0100, 16'h0064});
    readExpect(CMD_VOUT, 1'b0, 16'h0800, 1'b0);
    readExpect(CMD_VOUT_PEAK, 1'b0, 16'h1000, 1'b0);
    readExpect(CMD_IOUT_PEAK, 1'b0, 16'he100, 1'b0);
    readExpect(CMD_TEMP_EXT_PEAK, 1'b0, 16'hf064, 1'b0);
    readExpect(CMD_VIN, 1'b1, 16'hc100, 1'b0);
    readExpect(CMD_VIN_PEAK, 1'b0, 16'hc300, 1'b0);
    fire(6'h01, 1'b0, '0, '0);
    readExpect(CMD_VOUT_PEAK, 1'b0, 16'h0000, 1'b0);
    // Empty linear peaks keep their base exponent with a zero mantissa
    readExpect(CMD_VIN_PEAK, 1'b0, 16'hc000, 1'b0);
    readExpect(CMD_IOUT_PEAK, 1'b1, 16'he000, 1'b0);
    readExpect(CMD_TEMP_INT_PEAK, 1'b0, 16'hf000, 1'b0);
    readExpect(CMD_TEMP_EXT_PEAK, 1'b0, 16'hf000, 1'b0);
    // Clear and sample on the same edge
    fire(6'h21, 1'b1, '{16'h0010, 10'h100, 16'h0400, 16'h0028}, '0);
    readExpect(CMD_VOUT_PEAK, 1'b1, 16'h0400, 1'b0);
    readExpect(CMD_IOUT_PEAK, 1'b1, 16'he010, 1'b0);
    readExpect(CMD_TEMP_EXT_PEAK, 1'b1, 16'hf028, 1'b0);
    readExpect(CMD_VOUT_PEAK, 1'b0, 16'h0000, 1'b0);
    // Temperature coefficient follows the external reading only
    @(posedge mclk);
    chanCfg[1].gainTc <= 16'h0100;
    fire(6'h30, 1'b1, '{16'h0080, 10'h100, 16'h0800, 16'h00c8}, '{16'h0100, 16'h0190});
    readExpect(CMD_IOUT, 1'b1, 16'he083, 1'b0);
    readExpect(CMD_IOUT, 1'b0, 16'he040, 1'b0);
    readExpect(CMD_TEMP_INT, 1'b0, 16'hf190, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      eccNoCorrect <= eccVal[i];
      fire(eccMask[i], 1'b0, '0, '0);
      eccNoCorrect <= ~eccVal[i];
      readExpect(CMD_ECC_INFO, 1'b0, {10'h000, eccVal[i], 5'h00}, 1'b0);
    end
    // Second reset refreshes the status bit and empties readings
    @(posedge mclk);
    eccNoCorrect <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    readExpect(CMD_ECC_INFO, 1'b1, 16'h0020, 1'b0);
    readExpect(CMD_VOUT_PEAK, 1'b0, 16'h0000, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
